// [tap_defines.vh]
// Constants for the boundary-scan test port
// Notes on behaviour
// - One standard test port scans the pins
// - Outer port reaches inner chip port
// - Five TMS-high clocks reset the port
// - Identification word shifted, bit zero one
// - User code: user id, unused, revision
// - Unprogrammed fuses give zero user id
// - Reset input active low, asynchronous assertion
// - Boot starts only after clock lock
// - User id from security bits 31 to 22
`default_nettype none
`ifndef TAP_DEFINES_VH
`define TAP_DEFINES_VH
`define IR_WIDTH 4
`define DR_WIDTH 32
`define IR_EXTEST 4'h0
`define IR_SAMPLE 4'h1
`define IR_DEVICE_IDENTIFICATION_WORD 4'h2
`define IR_USERCODE 4'h3
`define IR_INNER 4'h4
`define IR_BYPASS 4'hf
`define IR_CAPTURE 4'h1
`define TMS_RESET_CLOCKS 3'h5
`define ID_VERSION 4'h0
`define ID_PART 16'h0000
`define ID_MAKER 11'h000
`define UC_REVISION 10'h000
`define UID_HI 31
`define UID_LO 22
`define UC_REV_HI 9
`define RESET_STRETCH 3'h3
`endif
`default_nettype wire

// [tap_port.v]
// Boundary-scan test access port with inner-port chaining and reset sequencing
`include "tap_defines.vh"
`default_nettype none
module tap_port #(
  parameter [3:0] id_version = `ID_VERSION, // arbitrary value
  parameter [15:0] id_part = `ID_PART, // arbitrary value
  parameter [10:0] id_maker = `ID_MAKER, // arbitrary value
  parameter [9:0] silicon_revision = `UC_REVISION // arbitrary value
) (
  input wire clk,
  input wire reset,
  input wire ce,
  input wire rst_n_pin,
  input wire pll_locked,
  input wire [31:0] security_word,
  input wire tck,
  input wire tms,
  input wire tdi,
  output reg tdo,
  output reg tdo_oe,
  input wire inner_tdo,
  output reg inner_tck,
  output reg inner_tms,
  output reg inner_tdi,
  input wire [`DR_WIDTH-1:0] pin_sample,
  output reg [`DR_WIDTH-1:0] pin_drive,
  output reg pin_extest,
  output reg boot_start
);
  localparam [3:0] S_RESET = 4'h0, S_IDLE = 4'h1, S_SEL_DR = 4'h2, S_CAP_DR = 4'h3,
    S_SH_DR = 4'h4, S_EX1_DR = 4'h5, S_PAU_DR = 4'h6, S_EX2_DR = 4'h7, S_UPD_DR = 4'h8,
    S_SEL_IR = 4'h9, S_CAP_IR = 4'ha, S_SH_IR = 4'hb, S_EX1_IR = 4'hc, S_PAU_IR = 4'hd,
    S_EX2_IR = 4'he, S_UPD_IR = 4'hf;
  localparam [1:0] B_HOLD = 2'h0, B_WAIT = 2'h1, B_RUN = 2'h2;
  // Async assert, sync release: stretch keeps logic in reset
  reg [2:0] arst_reg;
  always @(posedge clk or negedge rst_n_pin)
    if (!rst_n_pin)
      arst_reg <= 3'h0;
    else if (ce)
      arst_reg <= {arst_reg[1:0], 1'b1};
  // Pin reset clears state at once, release waits for the stretch
  wire pin_rst = ~arst_reg[2];
  // Two-flop synchronisers for pins and the test clock
  reg [3:0] s1_reg, s2_reg;
  reg tck_prev_reg;
  // Pin levels pass two flops too, as they change off our clock
  reg [`DR_WIDTH-1:0] ps1_reg, ps2_reg;
  always @(posedge clk)
    if (reset)
    begin
      s1_reg <= 4'h0;
      s2_reg <= 4'h0;
      tck_prev_reg <= 1'b0;
      ps1_reg <= 32'h0;
      ps2_reg <= 32'h0;
    end
    else if (ce)
    begin
      s1_reg <= {tck, tms, tdi, inner_tdo};
      s2_reg <= s1_reg;
      tck_prev_reg <= s2_reg[3];
      // Oversampled test clock: each half must last four clocks
      ps1_reg <= pin_sample;
      ps2_reg <= ps1_reg;
    end
  wire tck_s = s2_reg[3];
  wire tms_s = s2_reg[2];
  wire tdi_s = s2_reg[1];
  wire itdo_s = s2_reg[0];
  wire rise = ce & tck_s & ~tck_prev_reg;
  wire fall = ce & ~tck_s & tck_prev_reg;
  // Next state of the standard controller
  function [3:0] tap_next;
    input [3:0] st;
    input m;
    case (st)
      S_RESET: tap_next = m ? S_RESET : S_IDLE;
      S_IDLE: tap_next = m ? S_SEL_DR : S_IDLE;
      S_SEL_DR: tap_next = m ? S_SEL_IR : S_CAP_DR;
      S_CAP_DR: tap_next = m ? S_EX1_DR : S_SH_DR;
      S_SH_DR: tap_next = m ? S_EX1_DR : S_SH_DR;
      S_EX1_DR: tap_next = m ? S_UPD_DR : S_PAU_DR;
      S_PAU_DR: tap_next = m ? S_EX2_DR : S_PAU_DR;
      S_EX2_DR: tap_next = m ? S_UPD_DR : S_SH_DR;
      S_UPD_DR: tap_next = m ? S_SEL_DR : S_IDLE;
      S_SEL_IR: tap_next = m ? S_RESET : S_CAP_IR;
      S_CAP_IR: tap_next = m ? S_EX1_IR : S_SH_IR;
      S_SH_IR: tap_next = m ? S_EX1_IR : S_SH_IR;
      S_EX1_IR: tap_next = m ? S_UPD_IR : S_PAU_IR;
      S_PAU_IR: tap_next = m ? S_EX2_IR : S_PAU_IR;
      S_EX2_IR: tap_next = m ? S_UPD_IR : S_SH_IR;
      S_UPD_IR: tap_next = m ? S_SEL_DR : S_IDLE;
      default: tap_next = S_RESET;
    endcase
  endfunction
  // Pin-scan instructions share capture and update paths
  function pin_scan;
    input [3:0] code;
    pin_scan = (code == `IR_EXTEST) || (code == `IR_SAMPLE);
  endfunction
  reg [3:0] state_reg, ir_reg, ir_sh_reg;
  reg [2:0] ones_reg;
  reg [`DR_WIDTH-1:0] dr_reg;
  reg [1:0] boot_reg;
  // Captured words: id with bit zero set, user code with its user id from fuses
  // Unprogrammed fuses read zero, so the field follows them
  wire [31:0] id_word = {id_version, id_part, id_maker, 1'b1};
  wire [31:0] uc_word = {security_word[`UID_HI:`UID_LO], 12'h000, silicon_revision};
  wire inner_sel = (ir_reg == `IR_INNER);
  wire bypass = (ir_reg != `IR_DEVICE_IDENTIFICATION_WORD) && (ir_reg != `IR_USERCODE) && !pin_scan(ir_reg) && !inner_sel;
  always @(posedge clk or posedge pin_rst)
    if (pin_rst)
    begin
      state_reg <= S_RESET;
      ir_reg <= `IR_DEVICE_IDENTIFICATION_WORD;
      ir_sh_reg <= 4'h0;
      ones_reg <= 3'h0;
      dr_reg <= 32'h0;
      pin_drive <= 32'h0;
      pin_extest <= 1'b0;
      tdo <= 1'b0;
      tdo_oe <= 1'b0;
      inner_tck <= 1'b0;
      inner_tms <= 1'b1;
      inner_tdi <= 1'b0;
    end
    else if (reset)
    begin
      state_reg <= S_RESET;
      ir_reg <= `IR_DEVICE_IDENTIFICATION_WORD;
      ir_sh_reg <= 4'h0;
      ones_reg <= 3'h0;
      dr_reg <= 32'h0;
      pin_drive <= 32'h0;
      pin_extest <= 1'b0;
      tdo <= 1'b0;
      tdo_oe <= 1'b0;
      inner_tck <= 1'b0;
      inner_tms <= 1'b1;
      inner_tdi <= 1'b0;
    end
    else if (ce)
    begin
      inner_tck <= tck_s & inner_sel;
      if (rise)
      begin
        inner_tms <= tms_s;
        inner_tdi <= tdi_s;
        // Five consecutive high TMS clocks force reset
        ones_reg <= tms_s ? (ones_reg == `TMS_RESET_CLOCKS ? ones_reg : ones_reg + 3'h1) : 3'h0;
        if (tms_s && ones_reg == `TMS_RESET_CLOCKS - 3'h1)
          state_reg <= S_RESET;
        else
          state_reg <= tap_next(state_reg, tms_s);
        case (state_reg)
          S_RESET:
          begin
            ir_reg <= `IR_DEVICE_IDENTIFICATION_WORD;
            pin_extest <= 1'b0;
          end
          S_CAP_IR: ir_sh_reg <= `IR_CAPTURE;
          S_SH_IR: ir_sh_reg <= {tdi_s, ir_sh_reg[3:1]};
          S_UPD_IR:
          begin
            ir_reg <= ir_sh_reg;
            pin_extest <= (ir_sh_reg == `IR_EXTEST);
          end
          S_CAP_DR:
            if (ir_reg == `IR_DEVICE_IDENTIFICATION_WORD)
              dr_reg <= id_word;
            else if (ir_reg == `IR_USERCODE)
              dr_reg <= uc_word;
            else if (pin_scan(ir_reg))
              dr_reg <= ps2_reg;
            else
              dr_reg <= 32'h0;
          S_SH_DR: dr_reg <= bypass ? {31'h0, tdi_s} : {tdi_s, dr_reg[31:1]};
          S_UPD_DR:
            if (pin_scan(ir_reg))
              pin_drive <= dr_reg;
          default: ;
        endcase
      end
      // Output changes on the falling edge, as the standard asks
      if (fall)
      begin
        tdo_oe <= (state_reg == S_SH_DR) || (state_reg == S_SH_IR);
        if (state_reg == S_SH_IR)
          tdo <= ir_sh_reg[0];
        else if (inner_sel)
          tdo <= itdo_s;
        else
          tdo <= dr_reg[0];
      end
    end
  // Boot waits for the synthesiser lock after release
  reg lock1_reg, lock2_reg;
  always @(posedge clk or posedge pin_rst)
    if (pin_rst)
    begin
      lock1_reg <= 1'b0;
      lock2_reg <= 1'b0;
      boot_reg <= B_HOLD;
      boot_start <= 1'b0;
    end
    else if (reset)
    begin
      lock1_reg <= 1'b0;
      lock2_reg <= 1'b0;
      boot_reg <= B_HOLD;
      boot_start <= 1'b0;
    end
    else if (ce)
    begin
      lock1_reg <= pll_locked;
      lock2_reg <= lock1_reg;
      boot_start <= 1'b0;
      case (boot_reg)
        B_HOLD: boot_reg <= B_WAIT;
        B_WAIT:
          if (lock2_reg)
          begin
            boot_reg <= B_RUN;
            boot_start <= 1'b1;
          end
        B_RUN: boot_reg <= B_RUN;
        default: boot_reg <= B_HOLD;
      endcase
    end
endmodule // tap_port
`default_nettype wire

// [tap_port_asserts.sv]
// Concurrent checks on the test port pins
`default_nettype none
module tap_port_asserts (
  input wire logic clk,
  input wire logic reset,
  input wire logic rst_n_pin,
  input wire logic pll_locked,
  input wire logic tck,
  input wire logic tdo,
  input wire logic tdo_oe,
  input wire logic inner_tms,
  input wire logic [31:0] pin_drive,
  input wire logic boot_start
);
  default clocking @(posedge clk); endclocking
  // Pin reset release is stretched, so all checks but a_pin_reset rest while it is low
  default disable iff (reset || !rst_n_pin);
  a_boot_lock: assert property (boot_start |-> pll_locked) else $error("boot without lock");
  a_boot_once: assert property (boot_start |=> !boot_start [*8]) else $error("boot repeated");
  a_pin_reset: assert property (disable iff (reset) !rst_n_pin |-> !boot_start && !tdo_oe && inner_tms)
    else $error("pin reset ignored");
  a_sync_reset: assert property (disable iff (!rst_n_pin) reset |=> !tdo_oe && !tdo && inner_tms)
    else $error("reset state wrong");
  a_oe_rise: assert property ($rose(tdo_oe) |-> !$past(tck, 2)) else $error("shift entry off tck");
  a_oe_fall: assert property ($fell(tdo_oe) |-> !$past(tck, 2)) else $error("shift exit off tck");
  a_tdo_fall: assert property ($changed(tdo) |-> !$past(tck, 2)) else $error("tdo not on fall");
  a_drive_quiet: assert property ($changed(pin_drive) |-> !tdo_oe) else $error("drive changed in shift");
endmodule // tap_port_asserts
bind tap_port tap_port_asserts chk (.clk(clk), .reset(reset), .rst_n_pin(rst_n_pin), .pll_locked(pll_locked),
  .tck(tck), .tdo(tdo), .tdo_oe(tdo_oe), .inner_tms(inner_tms), .pin_drive(pin_drive), .boot_start(boot_start));
`default_nettype wire

// [jtag_host.sv]
// External test controller model
`default_nettype none
module jtag_host (
  input wire logic clk,
  input wire logic tdo,
  output logic tck,
  output logic tms,
  output logic tdi
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {tck, tms, tdi} = 3'h2;
  // Pins move while tck is low; tdo taken late in the high half, as it stands until the fall
  task automatic step(input logic m, input logic d, output logic o);
    tms = m;
    tdi = d;
    repeat (4) @(negedge clk);
    tck = 1'b1;
    repeat (4) @(negedge clk);
    o = tdo;
    tck = 1'b0;
  endtask
  task automatic scan(input int n, input logic [31:0] m, input logic [31:0] d, output logic [31:0] o);
    o = 32'h0;
    for (int i = 0; i < n; i++) step(m[i], d[i], o[i]);
  endtask
endmodule // jtag_host
`default_nettype wire

// [tb_tap_port.sv]
// Self-checking bench for the test port
`default_nettype none
module tb_tap_port;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, reset = 1, rst_n_pin = 0, pll_locked = 0;
  logic [31:0] security_word = 32'h0, pin_sample = 32'h5a3c96e1, q, junk;
  wire tck, tms, tdi, tdo, tdo_oe, inner_tck, inner_tms, inner_tdi, pin_extest, boot_start;
  wire [31:0] pin_drive;
  int n_fail = 0, tests_run = 0, n_inner = 0;
  // Identity parameters below are arbitrary
  tap_port #(.id_version(4'ha), .id_part(16'h5c3e), .id_maker(11'h2b5), .silicon_revision(10'h155)) dut (
    .clk(clk), .reset(reset), .ce(1'b1), .rst_n_pin(rst_n_pin), .pll_locked(pll_locked),
    .security_word(security_word), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe),
    .inner_tdo(inner_tdi), .inner_tck(inner_tck), .inner_tms(inner_tms), .inner_tdi(inner_tdi),
    .pin_sample(pin_sample), .pin_drive(pin_drive), .pin_extest(pin_extest), .boot_start(boot_start));
  jtag_host h (.clk(clk), .tdo(tdo), .tck(tck), .tms(tms), .tdi(tdi));
  initial forever #12.5 clk = ~clk;
  always @(posedge inner_tck) n_inner++;
  task chk(input logic ok, input string m);
    tests_run++;
    if (ok !== 1'b1)
    begin
      n_fail++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask
  task ir(input logic [3:0] v);
    h.scan(4, 32'h3, 32'h0, q);
    h.scan(4, 32'h8, {28'h0, v}, q);
    chk(q[3:0] === 4'h1, "ir capture");
    h.scan(2, 32'h1, 32'h0, junk);
  endtask
  task dr(input int n, input logic [31:0] d);
    h.scan(3, 32'h1, 32'h0, junk);
    h.scan(n, 32'h1 << (n - 1), d, q);
    h.scan(2, 32'h1, 32'h0, junk);
  endtask
  task test_boot;
    // Pin held low through power-up, let go a millisecond on
    repeat (40040) @(negedge clk);
    rst_n_pin = 1'b1;
    repeat (10) @(negedge clk);
    chk(boot_start === 1'b0, "boot at power-up");
    rst_n_pin = 1'b0;
    repeat (8) @(negedge clk);
    rst_n_pin = 1'b1;
    repeat (10) @(negedge clk);
    chk(boot_start === 1'b0, "boot before lock");
    pll_locked = 1'b1;
    for (int i = 0; i < 20 && boot_start !== 1'b1; i++) @(negedge clk);
    chk(boot_start === 1'b1, "no boot");
  endtask
  task test_usercode;
    h.scan(6, 32'h1f, 32'h0, junk);
    test_code(32'h0);
    test_code(32'hb4ffffff);
  endtask
  task test_reset;
    reset = 1'b1;
    repeat (2) @(negedge clk);
    reset = 1'b0;
    repeat (2) @(negedge clk);
    chk(tdo_oe === 1'b0 && tdo === 1'b0 && inner_tms === 1'b1, "sync reset");
    h.scan(1, 32'h0, 32'h0, junk);
    dr(32, 32'h0);
    chk(q === {4'ha, 16'h5c3e, 11'h2b5, 1'b1}, "id after reset");
  endtask
  task test_code(input logic [31:0] s);
    security_word = s;
    ir(4'h3);
    dr(32, 32'h0);
    chk(q === {s[31:22], 12'h0, 10'h155}, "user code");
  endtask
  task test_device_identification_word;
    h.scan(6, 32'h1f, 32'h0, junk);
    dr(32, 32'h0);
    chk(q === {4'ha, 16'h5c3e, 11'h2b5, 1'b1}, "id word");
  endtask
  task test_pins;
    for (int i = 0; i < 2; i++)
    begin
      ir(i[3:0]);
      dr(32, 32'h1234abcd ^ i);
      chk(q === pin_sample, "pin capture");
      chk(pin_drive === (32'h1234abcd ^ i), "pin update");
      chk(pin_extest === ~i[0], "extest mode");
    end
  endtask
  task test_inner;
    ir(4'h4);
    n_inner = 0;
    dr(8, 32'h5a);
    chk(n_inner === 13, "inner clock");
    chk(q[7:0] === 8'hb4, "inner data");
    ir(4'hf);
    dr(8, 32'ha5);
    chk(q[7:0] === 8'h4a, "bypass");
  endtask
  task test_done;
    $display("checks %0d failures %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (6) @(negedge clk);
    reset = 1'b0;
    test_boot;
    test_usercode;
    test_reset;
    test_device_identification_word;
    test_pins;
    test_inner;
    test_done;
  end
  initial
  begin
    #1500000;
    n_fail++;
    test_done;
  end
endmodule // tb_tap_port
`default_nettype wire
